/* File: rtl/clock_source_status_flags.sv */
// status flags, lock tracking and oscillator enable of the internal clock unit
`timescale 1ns/10ps
`include "clock_status_regs.svh"
module clock_source_status_flags
    import clock_status_pkg::*;
#(
    parameter int LOCK_QUAL_CYCLES = `CSF_LOCK_QUAL_CYC
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // loop and clock selection inputs
    input wire logic fll_enable_in,
    input wire logic freq_in_tolerance_in,
    input wire logic stop_mode_in,
    input wire logic reference_select_in,
    input wire logic [2:0] reference_divider_in,
    input wire logic [7:0] trim_in,
    input wire logic [1:0] clock_select_in,
    // outputs
    output logic lock_status_out,
    output logic oscillator_enable_out,
    output logic irq_out
);

    csf_state_s state_ff;
    csf_state_s nxt_state;
    logic [2:0] sel_sync;
    logic ref_status;
    logic [1:0] mode_sync;
    logic [2:0] sel_raw;

    // terminal count of the lock qualifier, cut to the counter's width on purpose
    localparam logic [15:0] QUAL_LAST = 16'(LOCK_QUAL_CYCLES - 1);

    initial
    begin
        if (LOCK_QUAL_CYCLES < 1 || LOCK_QUAL_CYCLES > 65535)
        begin
            $error("clock_source_status_flags: LOCK_QUAL_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode, used in the address phase only; the read mux takes the stored select
    function automatic reg_sel_e decode(input logic [31:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == {14'h0000, `CSF_IDX_STATUS, 2'h0})
        begin
            sel = SEL_STATUS;
        end
        else if (addr == {14'h0000, `CSF_IDX_OSC, 2'h0})
        begin
            sel = SEL_OSC;
        end
        else if (addr == {14'h0000, `CSF_IDX_LOOP_CTRL, 2'h0})
        begin
            sel = SEL_LOOP_CTRL;
        end
        else if (addr == {14'h0000, `CSF_IDX_IRQ_STAT, 2'h0})
        begin
            sel = SEL_IRQ_STAT;
        end
        else if (addr == {14'h0000, `CSF_IDX_IRQ_MASK, 2'h0})
        begin
            sel = SEL_IRQ_MASK;
        end
        return sel;
    endfunction

    // read value of a register; unmapped space reads zero
    function automatic logic [7:0] read_value(
        input reg_sel_e sel,
        input csf_state_s st,
        input logic refst
    );
        logic [7:0] v;
        v = 8'h00; // reserved bits, bit 5 among them, stay zero
        case (sel)
            SEL_STATUS:
            begin
                v[`CSF_LOSS_OF_LOCK_FLAG_BIT] = st.lol_flag;
                v[`CSF_LOCK_BIT] = st.lock;
                v[`CSF_REFST_BIT] = refst;
                v[`CSF_MODE_HI:`CSF_MODE_LO] = st.clk_mode;
            end
            SEL_OSC:
            begin
                v[`CSF_OSCILLATOR_ENABLE_BIT] = st.osc_en;
            end
            SEL_LOOP_CTRL:
            begin
                v[`CSF_LOSS_OF_LOCK_IRQ_ENABLE_BIT] = st.lol_irq_en;
            end
            SEL_IRQ_STAT:
            begin
                v[2:0] = st.irq_stat;
            end
            SEL_IRQ_MASK:
            begin
                v[2:0] = st.irq_mask;
            end
            default:
            begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // change of reference, divider or, on the internal reference only, trim
    function automatic logic cfg_moved(
        input logic ref_sel,
        input logic [2:0] div,
        input logic [7:0] trim,
        input csf_state_s st
    );
        logic trim_moved;
        trim_moved = ref_sel & (trim != st.trim_prev);
        return (ref_sel != st.ref_sel_prev) | (div != st.div_prev) | trim_moved;
    endfunction

    // request level: loss flag through its enable, events through their mask
    function automatic logic irq_level(input csf_state_s st);
        logic lvl;
        lvl = st.lol_flag & st.lol_irq_en;
        lvl = lvl | (|(st.irq_stat & st.irq_mask));
        return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reference select on top, clock select below, bundled for one synchroniser
    assign sel_raw = {reference_select_in, clock_select_in};

    // select bits cross from the clock unit's domain before they are reported
    sync_stage #(
        .WIDTH(3)
    ) sync_stage_inst (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .async_in(sel_raw),
        .sync_out(sel_sync)
    );

    // status follows the select only after the synchroniser delay
    assign ref_status = sel_sync[2];
    assign mode_sync = sel_sync[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus slave, lock tracking, flags and interrupt
    always_comb
    begin
        logic accept;
        logic wr_now;
        logic rd_now;
        logic cfg_change;
        logic stop_entry;
        logic run;
        logic lose;
        logic acquire;
        logic mode_change;
        logic [2:0] events;

        accept = 1'b0;
        wr_now = 1'b0;
        rd_now = 1'b0;
        cfg_change = 1'b0;
        stop_entry = 1'b0;
        run = 1'b0;
        lose = 1'b0;
        acquire = 1'b0;
        mode_change = 1'b0;
        events = 3'h0;
        nxt_state = state_ff;

        // bus phases; reads take one wait state so read data comes from a flop
        accept = hsel_in & htrans_in[1] & hready_in;
        case (state_ff.bus_st)
            BUS_IDLE, BUS_READ_DONE:
            begin
                nxt_state.bus_st = BUS_IDLE;
            end
            BUS_WRITE:
            begin
                wr_now = 1'b1;
                nxt_state.bus_st = BUS_IDLE;
            end
            BUS_READ:
            begin
                rd_now = 1'b1;
                nxt_state.rdata = read_value(state_ff.sel, state_ff, ref_status);
                nxt_state.bus_st = BUS_READ_DONE;
            end
            default:
            begin
                nxt_state.bus_st = BUS_IDLE;
            end
        endcase
        // a new address phase may overlap a write data phase
        if (accept && state_ff.bus_st != BUS_READ)
        begin
            nxt_state.sel = decode(haddr_in);
            nxt_state.bus_st = hwrite_in ? BUS_WRITE : BUS_READ;
        end

        // software writes; hardware status fields ignore data
        if (wr_now)
        begin
            case (state_ff.sel)
                SEL_OSC:
                begin
                    nxt_state.osc_en = hwdata_in[`CSF_OSCILLATOR_ENABLE_BIT];
                end
                SEL_LOOP_CTRL:
                begin
                    nxt_state.lol_irq_en = hwdata_in[`CSF_LOSS_OF_LOCK_IRQ_ENABLE_BIT];
                end
                SEL_IRQ_MASK:
                begin
                    nxt_state.irq_mask = hwdata_in[2:0];
                end
                SEL_STATUS:
                begin
                    // write one clears a set flag, zero leaves it alone
                    if (hwdata_in[`CSF_LOSS_OF_LOCK_FLAG_BIT] && state_ff.lol_flag)
                    begin
                        nxt_state.lol_flag = 1'b0;
                    end
                end
                default:
                begin
                    nxt_state.sel = state_ff.sel;
                end
            endcase
        end

        // reading the event register clears it; new events set it below
        if (rd_now && state_ff.sel == SEL_IRQ_STAT)
        begin
            nxt_state.irq_stat = 3'h0;
        end

        // a trim change matters only with the internal reference in use
        cfg_change = cfg_moved(reference_select_in, reference_divider_in, trim_in, state_ff);
        stop_entry = stop_mode_in & ~state_ff.stop_prev;
        run = fll_enable_in & ~stop_mode_in;
        nxt_state.ref_sel_prev = reference_select_in;
        nxt_state.div_prev = reference_divider_in;
        nxt_state.trim_prev = trim_in;
        nxt_state.stop_prev = stop_mode_in;

        // deliberate reconfiguration is not a loss of lock, only drift is
        lose = run & state_ff.lock & ~freq_in_tolerance_in
            & ~cfg_change & ~stop_entry;

        // lock is qualified by a run of in-tolerance cycles
        if (!run || cfg_change || stop_entry || lose)
        begin
            nxt_state.lock = 1'b0;
            nxt_state.qual_cnt = 16'h0000;
        end
        else if (!freq_in_tolerance_in)
        begin
            nxt_state.qual_cnt = 16'h0000;
        end
        else if (!state_ff.lock)
        begin
            if (state_ff.qual_cnt == QUAL_LAST)
            begin
                nxt_state.lock = 1'b1;
                nxt_state.qual_cnt = 16'h0000;
                acquire = 1'b1;
            end
            else
            begin
                nxt_state.qual_cnt = state_ff.qual_cnt + 16'h0001;
            end
        end

        // a loss in the same cycle as a clear wins over the clear
        if (lose)
        begin
            nxt_state.lol_flag = 1'b1;
        end

        // clock mode status; the reserved select code keeps the last mode
        if (mode_sync != 2'h3)
        begin
            nxt_state.clk_mode = mode_sync;
        end
        mode_change = nxt_state.clk_mode != state_ff.clk_mode;

        // sticky events set after the read clear, so set wins
        events[`CSF_EV_LOST] = lose;
        events[`CSF_EV_ACQUIRED] = acquire;
        events[`CSF_EV_MODE] = mode_change;
        nxt_state.irq_stat = nxt_state.irq_stat | events;

        // request while the loss flag is set and enabled, or while an unmasked event is pending
        nxt_state.irq = irq_level(nxt_state);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset clears the flag and every control bit
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_ff <= '0;
            state_ff.bus_st <= BUS_IDLE;
            state_ff.sel <= SEL_NONE;
            state_ff.lol_flag <= 1'b0;
            state_ff.osc_en <= `CSF_RST_OSCILLATOR_ENABLE;
            state_ff.lol_irq_en <= `CSF_RST_LOSS_OF_LOCK_IRQ_ENABLE;
            state_ff.irq_mask <= `CSF_RST_MASK;
            state_ff.clk_mode <= `CSF_RST_MODE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; the response is always okay
    assign hrdata_out = {24'h000000, state_ff.rdata};
    assign hreadyout_out = state_ff.bus_st != BUS_READ;
    assign hresp_out = 1'b0;
    assign lock_status_out = state_ff.lock;
    assign oscillator_enable_out = state_ff.osc_en;
    assign irq_out = state_ff.irq;

endmodule

/* File: rtl/clock_status_regs.svh */
// register map, field positions, reset values and timing of the clock source status block
// Functional notes
// - flag sets on lost lock after acquisition
// - reset or write one clears flag
// - flag raises request when enable set
// - lock indicator reports current lock
// - loop disabled turns lock detection off
// - reference, divider, internal trim change clears lock
// - stop entry clears lock until relock
// - reference source status: 1 internal
// - reference status follows after synchroniser delay
// - clock mode status encoding 00/01/10
// - clock mode status follows after synchroniser
// - reserved status bits read zero
// - oscillator enable bit drives oscillator
// - enable only matters while flag set
`ifndef CLOCK_STATUS_REGS_SVH
`define CLOCK_STATUS_REGS_SVH

// register indices; byte address is four times the index
`define CSF_IDX_LOOP_CTRL 16'h303B
`define CSF_IDX_STATUS 16'h303C
`define CSF_IDX_OSC 16'h303E
`define CSF_IDX_IRQ_STAT 16'h3040
`define CSF_IDX_IRQ_MASK 16'h3041

// status register fields
`define CSF_LOSS_OF_LOCK_FLAG_BIT 7
`define CSF_LOCK_BIT 6
`define CSF_REFST_BIT 4
`define CSF_MODE_HI 3
`define CSF_MODE_LO 2

// control fields
`define CSF_LOSS_OF_LOCK_IRQ_ENABLE_BIT 7
`define CSF_OSCILLATOR_ENABLE_BIT 7

// interrupt event bits
`define CSF_EV_LOST 0
`define CSF_EV_ACQUIRED 1
`define CSF_EV_MODE 2

// reset values
`define CSF_RST_OSCILLATOR_ENABLE 1'b0
`define CSF_RST_LOSS_OF_LOCK_IRQ_ENABLE 1'b0
`define CSF_RST_MASK 3'h0
`define CSF_RST_MODE 2'h0

// lock qualification time and clock period
`define CSF_LOCK_QUAL_NS 200
`define CSF_CLK_PERIOD_NS 10
`define CSF_LOCK_QUAL_CYC ((`CSF_LOCK_QUAL_NS + `CSF_CLK_PERIOD_NS - 1) / `CSF_CLK_PERIOD_NS)

`endif

/* File: rtl/clock_status_pkg.sv */
// types shared by the clock source status block
package clock_status_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ,
        BUS_READ_DONE
    } bus_state_e;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_STATUS,
        SEL_OSC,
        SEL_LOOP_CTRL,
        SEL_IRQ_STAT,
        SEL_IRQ_MASK
    } reg_sel_e;

    typedef struct packed {
        bus_state_e bus_st;
        reg_sel_e sel;
        logic [7:0] rdata;
        logic lol_flag;
        logic lock;
        logic [15:0] qual_cnt;
        logic ref_sel_prev;
        logic [2:0] div_prev;
        logic [7:0] trim_prev;
        logic stop_prev;
        logic lol_irq_en;
        logic osc_en;
        logic [1:0] clk_mode;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
    } csf_state_s;

endpackage

/* File: rtl/sync_stage.sv */
// two-flop level synchroniser for a small bundle of bits
`timescale 1ns/10ps
module sync_stage
#(
    parameter int WIDTH = 3
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_s;

    sync_state_s sync_ff;
    sync_state_s nxt_sync;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("sync_stage: WIDTH must be at least 1");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_comb
    begin
        nxt_sync = sync_ff;
        nxt_sync.meta = async_in;
        nxt_sync.stable = sync_ff.meta;
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync_ff <= '0;
        end
        else
        begin
            sync_ff <= nxt_sync;
        end
    end

    assign sync_out = sync_ff.stable;

endmodule

/* File: verification/clock_source_status_flags_checker.sv */
// port-level assertions for the clock source status block
`timescale 1ns/10ps
`include "clock_status_regs.svh"
module clock_source_status_flags_checker
#(
    parameter int LOCK_QUAL_CYCLES = `CSF_LOCK_QUAL_CYC
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic fll_enable_in,
    input wire logic freq_in_tolerance_in,
    input wire logic stop_mode_in,
    input wire logic reference_select_in,
    input wire logic [2:0] reference_divider_in,
    input wire logic [7:0] trim_in,
    input wire logic [1:0] clock_select_in,
    input wire logic lock_status_out,
    input wire logic oscillator_enable_out,
    input wire logic irq_out
);
    int good_ff;
    logic rd_take, wr_take, wr_osc;
    assign rd_take = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
    assign wr_take = hsel_in & htrans_in[1] & hready_in & hwrite_in;
    assign wr_osc = wr_take && (haddr_in == 32'({`CSF_IDX_OSC, 2'b00}));
    ////////////////////////////////////////////////////////////////////////////////
    // run of edges on which the loop could qualify lock; config changes only delay it
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in)
            good_ff <= 0;
        else
            good_ff <= (fll_enable_in & ~stop_mode_in & freq_in_tolerance_in) ? good_ff + 1 : 0;
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    AST_WR_NOWAIT: assert property (wr_take |=> hreadyout_out)
        else $error("write stalled");
    AST_RD_WAIT: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    AST_RESP_OKAY: assert property (hresp_out == 1'b0)
        else $error("error response seen");
    AST_LOCK_QUAL: assert property ($rose(lock_status_out) |-> good_ff >= LOCK_QUAL_CYCLES)
        else $error("lock set too early");
    AST_DRIFT: assert property (lock_status_out && !freq_in_tolerance_in |=> !lock_status_out)
        else $error("lock kept after drift");
    AST_LOOP_OFF: assert property (!fll_enable_in |=> !lock_status_out)
        else $error("lock with loop off");
    AST_STOP: assert property (stop_mode_in |=> !lock_status_out)
        else $error("lock kept in stop");
    AST_CFG_CHG: assert property ($changed(reference_select_in) || $changed(reference_divider_in)
        |=> !lock_status_out)
        else $error("lock kept after config change");
    AST_TRIM_INT: assert property (reference_select_in && $changed(trim_in) |=> !lock_status_out)
        else $error("lock kept after trim change");
    AST_OSC_WRITE: assert property ($changed(oscillator_enable_out) |-> $past(wr_osc, 2))
        else $error("oscillator enable moved without write");
    COV_LOCK: cover property ($rose(lock_status_out));
    COV_IRQ: cover property ($rose(irq_out));
    COV_READ: cover property (rd_take);
endmodule
bind clock_source_status_flags clock_source_status_flags_checker
    #(.LOCK_QUAL_CYCLES(LOCK_QUAL_CYCLES)) clock_source_status_flags_checker_inst (.*);

/* File: verification/clock_source_status_flags_test.sv */
// self-checking bench for the clock source status block
`timescale 1ns/10ps
`include "clock_status_regs.svh"
module test_clock_source_status_flags import clock_status_pkg::*;;
    localparam int QUAL = 3;
    localparam logic [31:0] a_ctrl = 32'({`CSF_IDX_LOOP_CTRL, 2'b00});
    localparam logic [31:0] a_stat = 32'({`CSF_IDX_STATUS, 2'b00});
    localparam logic [31:0] a_osc = 32'({`CSF_IDX_OSC, 2'b00});
    localparam logic [31:0] a_irqs = 32'({`CSF_IDX_IRQ_STAT, 2'b00});
    localparam logic [31:0] a_mask = 32'({`CSF_IDX_IRQ_MASK, 2'b00});
    localparam logic [31:0] a_none = 32'h0000_0010;
    logic clock_in, rst_n_in, hsel_in, hwrite_in, fll_enable_in, freq_in_tolerance_in;
    logic stop_mode_in, reference_select_in, hreadyout_out, hresp_out;
    logic lock_status_out, oscillator_enable_out, irq_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0] htrans_in, clock_select_in;
    logic [2:0] hsize_in, reference_divider_in;
    logic [7:0] trim_in;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    clock_source_status_flags #(.LOCK_QUAL_CYCLES(QUAL)) clock_source_status_flags_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .fll_enable_in(fll_enable_in),
        .freq_in_tolerance_in(freq_in_tolerance_in), .stop_mode_in(stop_mode_in),
        .reference_select_in(reference_select_in), .reference_divider_in(reference_divider_in),
        .trim_in(trim_in), .clock_select_in(clock_select_in), .lock_status_out(lock_status_out),
        .oscillator_enable_out(oscillator_enable_out), .irq_out(irq_out));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under two thousand cycles
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ready is sampled at the falling edge so the decision never races the rising one
    task automatic wait_ready(output logic [31:0] q);
        logic r;
        r = 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge clock_in);
            r = hreadyout_out;
            q = hrdata_out;
            @(posedge clock_in);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in <= a;
        wait_ready(q);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_ready(q);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // pins are looked at two edges on, at a falling edge
    task automatic pin(input logic got_sel, input logic exp);
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        check(32'(got_sel ? lock_status_out : irq_out), 32'(exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        logic [31:0] addrs [6] = '{a_ctrl, a_stat, a_osc, a_irqs, a_mask, a_none};
        foreach (addrs[i])
            rd(addrs[i], 32'h0);
        check(32'(oscillator_enable_out), 32'h0);
        check(32'(hresp_out), 32'h0);
    endtask
    task automatic t_osc();
        wr(a_osc, 32'hFF);
        rd(a_osc, 32'h80);
        check(32'(oscillator_enable_out), 32'h1);
        wr(a_osc, 32'h0);
        rd(a_osc, 32'h0);
        wr(a_none, 32'hFF);
        rd(a_none, 32'h0);
    endtask
    task automatic t_sync();
        logic [1:0] em;
        reference_select_in <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clock_in);
            clock_select_in <= 2'(m);
            em = (m == 3) ? 2'h2 : 2'(m);
            repeat (4) @(posedge clock_in);
            rd(a_stat, 32'h10 | 32'(em) << 2);
        end
        reference_select_in <= 1'b0;
        wr(a_stat, 32'hFF);
        repeat (4) @(posedge clock_in);
        rd(a_stat, 32'h08);
        rd(a_irqs, 32'h04);
    endtask
    task automatic t_lock();
        wr(a_mask, 32'h1);
        fll_enable_in <= 1'b1;
        freq_in_tolerance_in <= 1'b1;
        repeat (QUAL + 4) @(posedge clock_in);
        rd(a_stat, 32'h48);
        freq_in_tolerance_in <= 1'b0;
        pin(1'b0, 1'b1);
        rd(a_stat, 32'h88);
        rd(a_irqs, 32'h03);
        pin(1'b0, 1'b0);
        wr(a_ctrl, 32'h80);
        pin(1'b0, 1'b1);
        wr(a_stat, 32'h00);
        rd(a_stat, 32'h88);
        wr(a_stat, 32'h80);
        rd(a_stat, 32'h08);
        pin(1'b0, 1'b0);
    endtask
    // each case relocks, then disturbs the loop; only the last must keep lock
    task automatic t_clear();
        for (int k = 0; k < 7; k++)
        begin
            @(posedge clock_in);
            fll_enable_in <= 1'b1;
            stop_mode_in <= 1'b0;
            freq_in_tolerance_in <= 1'b1;
            // relock gets more than the qualification time, also after stop
            repeat (QUAL + 2) @(posedge clock_in);
            pin(1'b1, 1'b1);
            @(posedge clock_in);
            case (k)
                0: reference_select_in <= 1'b1;
                1: reference_divider_in <= reference_divider_in + 3'h1;
                2: trim_in <= trim_in + 8'h1;
                3: stop_mode_in <= 1'b1;
                4: fll_enable_in <= 1'b0;
                5: reference_select_in <= 1'b0;
                default: trim_in <= trim_in + 8'h1;
            endcase
            pin(1'b1, k == 6);
        end
        rd(a_stat, 32'h48);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        rst_n_in = 1'b0;
        hsel_in = 1'b0;
        haddr_in = 32'h0;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hsize_in = 3'h2;
        hwdata_in = 32'h0;
        fll_enable_in = 1'b0;
        freq_in_tolerance_in = 1'b0;
        stop_mode_in = 1'b0;
        reference_select_in = 1'b0;
        reference_divider_in = 3'h0;
        trim_in = 8'h0;
        clock_select_in = 2'h0;
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        t_reset();
        t_osc();
        t_sync();
        t_lock();
        t_clear();
        wrap_up();
    end
endmodule
